// ---- test_watchdog_timer.sv ----
// Purpose: Self-checking bench for the watchdog timer.
// Assumes: 25 MHz aclk; one watchdog tick every WDT_TICK_CYCLES clocks.
// Notes:   Registers are reached only through the AXI4-Lite tasks.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_timer_defines.vh"

module test_watchdog_timer;
   localparam int          tick_len = `WDT_TICK_CYCLES;
   localparam logic [23:0] rst_reload = `RELOAD_RESET;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic        always_on_option_bit = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   wire         awready, wready, bvalid, arready, rvalid, wdt_reset_request, irq;
   wire  [31:0] rdata;
   wire  [1:0]  bresp, rresp;
   logic [31:0] got;
   logic [1:0]  resp;
   int          fails = 0, checks_done = 0, n;

   watchdog_timer uut (.aclk, .aresetn, .always_on_option_bit, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .wdt_reset_request, .irq);

   // Free-running 40 ns clock.
   always #20 aclk = ~aclk;

   // ======================================================
   // Comparison, verdict and bus tasks.
   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] seen);
      check_word(what, {30'h0, exp}, {30'h0, seen});
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Each task ends one edge after its release, so no signal is driven twice in a time step.
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      logic done;
      done = 1'h0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!done)
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
         if (bvalid)
         begin
            done = 1'h1;
            resp = bresp;
            bready <= 1'h0;
         end
      end
      @(posedge aclk);
   endtask
   task automatic bus_read(input logic [7:0] a);
      logic done;
      done = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!done)
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'h0;
         if (rvalid)
         begin
            done = 1'h1;
            got = rdata;
            resp = rresp;
            rready <= 1'h0;
         end
      end
      @(posedge aclk);
   endtask
   task automatic expect_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus_read(a);
      check_word(what, exp, got);
      check_resp(what, `RESP_OKAY, resp);
   endtask
   // Reads the count until it shows v; the bound covers several ticks.
   task automatic poll_count(input logic [31:0] v);
      n = 0;
      got = 32'hffffffff;
      while (got !== v && n < 5000)
      begin
         bus_read(`REG_COUNT);
         n++;
      end
      check_word("count", v, got);
   endtask

   // ======================================================
   // Scenarios.
   task automatic t_reset_state;
      expect_reg("reload upper", `REG_RELOAD_UPPER, {24'h0, rst_reload[23:16]});
      expect_reg("reload high", `REG_RELOAD_HIGH, {24'h0, rst_reload[15:8]});
      expect_reg("reload low", `REG_RELOAD_LOW, {24'h0, rst_reload[7:0]});
      expect_reg("state off", `REG_STATE, 32'h0);
      bus_read(8'h28);
      check_resp("unmapped read", `RESP_SLVERR, resp);
      check_word("unmapped data", 32'h0, got);
      bus_write(`REG_COUNT, 32'h7);
      check_resp("read-only write", `RESP_SLVERR, resp);
      // An idle watchdog must let a whole tick pass without counting.
      repeat (tick_len + 100) @(posedge aclk);
      expect_reg("count off", `REG_COUNT, {8'h0, rst_reload});
   endtask
   task automatic t_enable;
      bus_write(`REG_RELOAD_UPPER, 32'h12);
      bus_write(`REG_RELOAD_HIGH, 32'h34);
      bus_write(`REG_RELOAD_LOW, 32'h56);
      bus_write(`REG_REFRESH, 32'h1);
      expect_reg("state on", `REG_STATE, 32'h1);
      poll_count(32'h123455);
   endtask
   task automatic t_retrigger;
      bus_write(`REG_RELOAD_UPPER, 32'h0);
      bus_write(`REG_RELOAD_HIGH, 32'h0);
      bus_write(`REG_RELOAD_LOW, 32'h5);
      bus_write(`REG_REFRESH, 32'h1);
      poll_count(32'h5);
      poll_count(32'h4);
      bus_write(`REG_REFRESH, 32'h1);
      poll_count(32'h5);
      n = 0;
      while (wdt_reset_request !== 1'h1 && n < 6 * tick_len)
      begin
         @(posedge aclk);
         n++;
      end
      check_word("time-out window", 32'h1, {31'h0, n > 4 * tick_len - 10 && n < 5 * tick_len + 5});
      check_word("irq reset mode", 32'h0, {31'h0, irq});
      expect_reg("status reset mode", `REG_IRQ_STATUS, 32'h0);
   endtask
   task automatic t_interrupt;
      bus_write(`REG_CONTROL, 32'h1);
      bus_write(`REG_IRQ_ENABLE, 32'h1);
      poll_count(32'h2);
      bus_write(`REG_REFRESH, 32'h1);
      n = 0;
      while (irq !== 1'h1 && n < 4 * tick_len)
      begin
         @(posedge aclk);
         n++;
      end
      check_word("irq time-out", 32'h1, {31'h0, irq});
      expect_reg("status both", `REG_IRQ_STATUS, 32'h3);
      bus_write(`REG_IRQ_CLEAR, 32'h1);
      check_word("irq masked", 32'h0, {31'h0, irq});
      bus_write(`REG_IRQ_ENABLE, 32'h3);
      check_word("irq unmasked", 32'h1, {31'h0, irq});
      bus_write(`REG_IRQ_CLEAR, 32'h2);
      check_word("irq cleared", 32'h0, {31'h0, irq});
      expect_reg("status cleared", `REG_IRQ_STATUS, 32'h0);
   endtask
   task automatic t_always_on;
      always_on_option_bit <= 1'h1;
      aresetn <= 1'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (4) @(posedge aclk);
      expect_reg("state always on", `REG_STATE, 32'h5);
      poll_count({8'h0, rst_reload - 24'h1});
   endtask

   // Main sequence: reset for 12 cycles, then every scenario in turn.
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_reset_state();
      t_enable();
      t_retrigger();
      t_interrupt();
      t_always_on();
      give_verdict();
   end

   // Hang guard, about twice the expected run length.
   initial
   begin
      repeat (90000) @(posedge aclk);
      fails++;
      give_verdict();
   end
endmodule
`default_nettype wire

// ---- watchdog_timer.v ----
// Purpose: Reloadable 24-bit watchdog timer with an AXI4-Lite register port.
// Assumes: aclk at 25 MHz; the oscillator rate is made by dividing it down.
// Notes:   A time-out either pulses a device reset request or raises an interrupt.
//
// How it works
// - Each refresh above count 000002H restarts the countdown; terminal count fires the selected response.
// - Control bit picks the response: device reset request or interrupt.
// - Counter steps on a dedicated 10 kHz tick, not the bus clock rate.
// - Only two states, off and on; once on it counts until reset.
// - Writing the refresh register, or the always-on option bit set at reset release, enables it.
// - With the always-on option bit set, counting starts right after reset.
// - Reload value is upper, high and low bytes joined, upper most significant.
// - Time-out lasts reload value ticks of 100 us, so reload/10 milliseconds.
// - At count 000002H or below, refresh attempts are ignored.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_timer_defines.vh"

module watchdog_timer
(
   input  wire                   aclk,
   input  wire                   aresetn,
   input  wire                   always_on_option_bit,
   input  wire [`ADDR_W-1:0]     awaddr,
   input  wire                   awvalid,
   output reg                    awready,
   input  wire [31:0]            wdata,
   input  wire [3:0]             wstrb,
   input  wire                   wvalid,
   output reg                    wready,
   output reg  [1:0]             bresp,
   output reg                    bvalid,
   input  wire                   bready,
   input  wire [`ADDR_W-1:0]     araddr,
   input  wire                   arvalid,
   output reg                    arready,
   output reg  [31:0]            rdata,
   output reg  [1:0]             rresp,
   output reg                    rvalid,
   input  wire                   rready,
   output reg                    wdt_reset_request,
   output reg                    irq
);

   localparam ST_OFF = 1'b0;
   localparam ST_ON  = 1'b1;
   // Full reset reload word, so each byte register takes its own slice of it.
   localparam [`COUNT_W-1:0] RELOAD_INIT = `RELOAD_RESET;

   // ==========================================================================
   // Declarations
   reg  [7:0]              reload_upper_byte;
   reg  [7:0]              reload_high_byte;
   reg  [7:0]              reload_low_byte;
   reg                     response_is_irq;
   reg                     state;
   reg                     next_state;
   reg                     refresh_pending;
   reg                     boot_pending;
   reg                     always_on_seen;
   reg  [`EVT_W-1:0]       irq_status;
   reg  [`EVT_W-1:0]       irq_enable;
   reg  [`ADDR_W-1:0]      wr_addr;
   reg                     aw_held;
   reg  [31:0]             wr_data;
   reg  [3:0]              wr_strb;
   reg                     w_held;
   reg                     cnt_load;
   reg                     cnt_dec;
   reg                     timeout_evt;
   reg                     ignored_evt;
   reg  [31:0]             next_rdata;
   reg  [1:0]              next_rresp;
   reg                     wr_ok;
   reg  [`EVT_W-1:0]       clear_bits;
   wire                    tick;
   wire [`COUNT_W-1:0]     count;
   wire [`COUNT_W-1:0]     reload_value;
   wire                    do_write;
   wire                    do_read;
   wire                    wr_byte0;
   wire                    refresh_write;
   wire                    refresh_allowed;

   // Reload value assembly, upper byte most significant.
   assign reload_value = {reload_upper_byte, reload_high_byte, reload_low_byte};

   // ==========================================================================
   // Oscillator tick and counter
   // The 10 kHz tick is an enable; the whole block stays on one clock.
   wdt_tick_divider u_tick
   (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .tick       (tick)
   );

   wdt_down_counter u_counter
   (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .load       (cnt_load),
      .load_value (reload_value),
      .dec        (cnt_dec),
      .count      (count)
   );

   // ==========================================================================
   // AXI4-Lite write channel
   // Address and data are captured independently and may come in either order.
   assign do_write      = aw_held && w_held && !bvalid;
   assign wr_byte0      = wr_strb[0];
   assign refresh_write = do_write && (wr_addr == `REG_REFRESH) && wr_byte0;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         awready <= 1'b0;
         wready  <= 1'b0;
         wr_addr <= {`ADDR_W{1'b0}};
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= `RESP_OKAY;
      end
      else
      begin
         awready <= !aw_held && !(awvalid && awready);
         wready  <= !w_held && !(wvalid && wready);
         if (awvalid && awready)
         begin
            aw_held <= 1'b1;
            wr_addr <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_held  <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // Write address decode; read-only registers answer with an error.
   always @*
   begin
      case (wr_addr)
         `REG_RELOAD_UPPER : wr_ok = 1'b1;
         `REG_RELOAD_HIGH  : wr_ok = 1'b1;
         `REG_RELOAD_LOW   : wr_ok = 1'b1;
         `REG_CONTROL      : wr_ok = 1'b1;
         `REG_REFRESH      : wr_ok = 1'b1;
         `REG_IRQ_CLEAR    : wr_ok = 1'b1;
         `REG_IRQ_ENABLE   : wr_ok = 1'b1;
         default           : wr_ok = 1'b0;
      endcase
   end

   // ==========================================================================
   // Software registers
   // Reload bytes are not range checked; a value below the minimum is the writer's fault.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         reload_upper_byte <= RELOAD_INIT[23:16];
         reload_high_byte  <= RELOAD_INIT[15:8];
         reload_low_byte   <= RELOAD_INIT[7:0];
         response_is_irq   <= `CTRL_RESET;
         irq_enable        <= {`EVT_W{1'b0}};
      end
      else if (do_write && wr_byte0)
      begin
         case (wr_addr)
            `REG_RELOAD_UPPER : reload_upper_byte <= wr_data[7:0];
            `REG_RELOAD_HIGH  : reload_high_byte  <= wr_data[7:0];
            `REG_RELOAD_LOW   : reload_low_byte   <= wr_data[7:0];
            `REG_CONTROL      : response_is_irq   <= wr_data[`CTRL_RESPONSE_BIT];
            `REG_IRQ_ENABLE   : irq_enable        <= wr_data[`EVT_W-1:0];
            default           : ;
         endcase
      end
   end

   // ==========================================================================
   // Watchdog control
   // A refresh can only restart the count while the count is above the lock value.
   assign refresh_allowed = (count > `REFRESH_LOCK_COUNT);

   always @*
   begin
      next_state  = state;
      cnt_load    = 1'b0;
      cnt_dec     = 1'b0;
      timeout_evt = 1'b0;
      ignored_evt = 1'b0;
      case (state)
         ST_OFF :
         begin
            // Either enable source starts the count from the full reload value.
            if (refresh_write || (boot_pending && always_on_option_bit))
            begin
               next_state = ST_ON;
               cnt_load   = 1'b1;
            end
         end
         ST_ON :
         begin
            // No path back to off: only a reset stops it.
            if (tick)
            begin
               if (refresh_pending && refresh_allowed)
                  cnt_load = 1'b1;
               else if (count <= `COUNT_ONE)
               begin
                  timeout_evt = 1'b1;
                  cnt_load    = 1'b1;
               end
               else
                  cnt_dec = 1'b1;
               if (refresh_pending && !refresh_allowed)
                  ignored_evt = 1'b1;
            end
         end
         default : next_state = ST_OFF;
      endcase
   end

   // State, refresh request and the one-shot capture of the option bit.
   // The option bit is read on the first cycle after reset release, never under reset.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state           <= ST_OFF;
         refresh_pending <= 1'b0;
         boot_pending    <= 1'b1;
         always_on_seen  <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         boot_pending <= 1'b0;
         if (boot_pending)
            always_on_seen <= always_on_option_bit;
         // A new refresh beats the tick that consumes the old one.
         if (refresh_write && state == ST_ON)
            refresh_pending <= 1'b1;
         else if (tick)
            refresh_pending <= 1'b0;
      end
   end

   // ==========================================================================
   // Time-out response and interrupt status
   // Status bits are sticky; an event in the clearing cycle wins over the clear.
   always @*
   begin
      clear_bits = {`EVT_W{1'b0}};
      if (do_write && wr_byte0 && wr_addr == `REG_IRQ_CLEAR)
         clear_bits = wr_data[`EVT_W-1:0];
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_status        <= {`EVT_W{1'b0}};
         irq               <= 1'b0;
         wdt_reset_request <= 1'b0;
      end
      else
      begin
         irq_status[`EVT_TIMEOUT_BIT] <= (timeout_evt && response_is_irq) ||
                                         (irq_status[`EVT_TIMEOUT_BIT] && !clear_bits[`EVT_TIMEOUT_BIT]);
         irq_status[`EVT_IGNORED_BIT] <= ignored_evt ||
                                         (irq_status[`EVT_IGNORED_BIT] && !clear_bits[`EVT_IGNORED_BIT]);
         irq               <= |(irq_status & irq_enable);
         wdt_reset_request <= timeout_evt && !response_is_irq;
      end
   end

   // ==========================================================================
   // AXI4-Lite read channel
   // One read at a time; arready drops while a read answer is outstanding.
   assign do_read = arvalid && arready;

   always @*
   begin
      next_rdata = 32'h00000000;
      next_rresp = `RESP_OKAY;
      case (araddr)
         `REG_RELOAD_UPPER : next_rdata[7:0] = reload_upper_byte;
         `REG_RELOAD_HIGH  : next_rdata[7:0] = reload_high_byte;
         `REG_RELOAD_LOW   : next_rdata[7:0] = reload_low_byte;
         `REG_CONTROL      : next_rdata[`CTRL_RESPONSE_BIT] = response_is_irq;
         `REG_REFRESH      : next_rdata = 32'h00000000;
         `REG_STATE        :
         begin
            next_rdata[`STATE_RUNNING_BIT]   = state;
            next_rdata[`STATE_PENDING_BIT]   = refresh_pending;
            next_rdata[`STATE_ALWAYS_ON_BIT] = always_on_seen;
         end
         `REG_COUNT        : next_rdata[`COUNT_W-1:0] = count;
         `REG_IRQ_STATUS   : next_rdata[`EVT_W-1:0] = irq_status;
         `REG_IRQ_CLEAR    : next_rdata = 32'h00000000;
         `REG_IRQ_ENABLE   : next_rdata[`EVT_W-1:0] = irq_enable;
         default           : next_rresp = `RESP_SLVERR;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= `RESP_OKAY;
      end
      else
      begin
         arready <= !rvalid && !do_read;
         if (do_read)
         begin
            rvalid <= 1'b1;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
         end
         else if (rvalid && rready)
            rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ---- watchdog_timer_defines.vh ----
// Purpose: Constants for the watchdog timer: register offsets, field positions, reset values, timing counts.
// Assumes: Included by its bare name from every design file of the watchdog.
// Notes:   Definitions only; no logic lives here.
`ifndef WATCHDOG_TIMER_DEFINES_VH
`define WATCHDOG_TIMER_DEFINES_VH

// ==========================================================================
// Register map (byte addresses on the AXI4-Lite bus)
`define ADDR_W              8
`define REG_RELOAD_UPPER    8'h00
`define REG_RELOAD_HIGH     8'h04
`define REG_RELOAD_LOW      8'h08
`define REG_CONTROL         8'h0c
`define REG_REFRESH         8'h10
`define REG_STATE           8'h14
`define REG_COUNT           8'h18
`define REG_IRQ_STATUS      8'h1c
`define REG_IRQ_CLEAR       8'h20
`define REG_IRQ_ENABLE      8'h24

// ==========================================================================
// Field positions
`define CTRL_RESPONSE_BIT   0
`define STATE_RUNNING_BIT   0
`define STATE_PENDING_BIT   1
`define STATE_ALWAYS_ON_BIT 2
`define EVT_TIMEOUT_BIT     0
`define EVT_IGNORED_BIT     1
`define EVT_W               2

// ==========================================================================
// Reset values and counter limits
`define COUNT_W             24
`define RELOAD_RESET        24'h000400
`define CTRL_RESET          1'b0
`define REFRESH_LOCK_COUNT  24'h000002
`define RELOAD_MIN          24'h000004
`define COUNT_ONE           24'h000001
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

// ==========================================================================
// Timing: the watchdog oscillator tick derived from the 25 MHz bus clock
`define CLK_PERIOD_NS       40
`define WDT_OSC_PERIOD_NS   100000
`define WDT_TICK_CYCLES     (`WDT_OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_CNT_W          12

`endif

// ---- watchdog_timer_properties.sv ----
// Purpose: Port-level assertions for the watchdog timer.
// Assumes: One clock aclk and a synchronous active-low aresetn.
// Notes:   Bound to every watchdog_timer instance at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_timer_defines.vh"

module wdt_checker
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        always_on_option_bit,
   input wire logic [7:0]  awaddr,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0]  wstrb,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        wdt_reset_request,
   input wire logic        irq
);
   // ======================================================
   // Cycles since the last reset request; it saturates, so a long run never wraps it.
   logic [15:0] gap;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         gap <= 16'hffff;
      else if (wdt_reset_request)
         gap <= 16'h0;
      else if (gap != 16'hffff)
         gap <= gap + 16'h1;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ======================================================
   // Assertions and covers.
   a_pulse_single: assert property (wdt_reset_request |=> !wdt_reset_request)
      else $error("reset request wider than one cycle");
   // The shortest legal period is four ticks of 2500 clocks.
   a_pulse_gap: assert property (wdt_reset_request |-> gap > 16'd9998)
      else $error("time-outs closer than four ticks");
   a_reset_quiet: assert property (disable iff (1'h0) !aresetn |=> !irq && !wdt_reset_request && !bvalid && !rvalid)
      else $error("outputs active after reset");
   a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped early");
   a_aw_refused: assert property (awvalid && awready |=> !awready)
      else $error("second write address accepted");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write answer late");
   a_bad_read: assert property (arvalid && arready && araddr > `REG_IRQ_ENABLE |=> rresp == `RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");
   c_pulse: cover property (wdt_reset_request);
   c_irq: cover property (irq);
   c_slverr: cover property (bvalid && bready && bresp == `RESP_SLVERR);
endmodule

bind watchdog_timer wdt_checker chk (.aclk, .aresetn, .always_on_option_bit, .awaddr, .awvalid, .awready, .wdata,
   .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
   .rready, .wdt_reset_request, .irq);
`default_nettype wire

// ---- wdt_down_counter.v ----
// Purpose: Loadable 24-bit down counter for the watchdog.
// Assumes: Load has priority over decrement.
// Notes:   Wraps are prevented by the caller, which reloads at terminal count.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_timer_defines.vh"

module wdt_down_counter
(
   input  wire                   aclk,
   input  wire                   aresetn,
   input  wire                   load,
   input  wire [`COUNT_W-1:0]    load_value,
   input  wire                   dec,
   output reg  [`COUNT_W-1:0]    count
);

   // ==========================================================================
   // Counter
   // Load wins so a reload can never lose against a decrement in the same cycle.
   always @(posedge aclk)
   begin
      if (!aresetn)
         count <= `RELOAD_RESET;
      else if (load)
         count <= load_value;
      else if (dec)
         count <= count - `COUNT_ONE;
   end

endmodule
`default_nettype wire

// ---- wdt_tick_divider.v ----
// Purpose: Divides the bus clock down to a one-cycle enable at the watchdog oscillator rate.
// Assumes: Single clock aclk, synchronous active-low reset.
// Notes:   Stands in for the dedicated RC oscillator; it runs free from reset.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_timer_defines.vh"

module wdt_tick_divider
(
   input  wire                   aclk,
   input  wire                   aresetn,
   output reg                    tick
);

   // The terminal count is worked out at full width and then cut to the counter width.
   localparam [31:0]            LAST_FULL = `WDT_TICK_CYCLES - 1;
   localparam [`TICK_CNT_W-1:0] LAST      = LAST_FULL[`TICK_CNT_W-1:0];

   reg [`TICK_CNT_W-1:0] div_count;

   // ==========================================================================
   // Divider
   // Free running so the tick phase never depends on software activity.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_count <= {`TICK_CNT_W{1'b0}};
         tick      <= 1'b0;
      end
      else if (div_count == LAST)
      begin
         div_count <= {`TICK_CNT_W{1'b0}};
         tick      <= 1'b1;
      end
      else
      begin
         div_count <= div_count + 1'b1;
         tick      <= 1'b0;
      end
   end

endmodule
`default_nettype wire
